// [hw/codec_ctl_pkg.sv]
// Contract
// - Tx codes 0-5 extended, +12 dB mic2
// - Tx codes 8-13 normal, 23.5 to 13.5
// - Tx gain resets to code 1000
// - Rx code 0 is +6, -1 dB steps
// - Rx gain resets to code 0111
// - Sidetone code 0 is -12, -2 dB steps
// - Power bit 7 mutes sidetone
// - Sidetone resets to code 000
// - Volume code 0 is 0 dB, -2 steps
// - Volume resets to code 0000
// - Exactly one earphone amplifier selected; both enables are low while presetn is low
// - Power bit 3 mutes earphone
// - Companded word eight bits, MSB first
// - Linear word fifteen bits, MSB first
// - Tones summed, same source feeds buzzer
// - Host rounds frequency over 7.8125 Hz
// - Tone registers at 04 and 05
// - High tone 2 dB above low tone
// - Host puts higher frequency in high
// - Reset loads every register default
package codec_ctl_pkg;
   // ==========================================================
   // Device register map
   localparam logic [2:0] ADDR_POWER  = 3'h0;
   localparam logic [2:0] ADDR_MODE   = 3'h1;
   localparam logic [2:0] ADDR_TXPGA  = 3'h2;
   localparam logic [2:0] ADDR_RXPGA  = 3'h3;
   localparam logic [2:0] ADDR_HITONE = 3'h4;
   localparam logic [2:0] ADDR_LOTONE = 3'h5;
   localparam int         NUM_REGS    = 6;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_POWER  = 8'h00;
   localparam logic [7:0] RST_MODE   = 8'h02;
   localparam logic [7:0] RST_TXPGA  = 8'h40;
   localparam logic [7:0] RST_RXPGA  = 8'h70;
   localparam logic [7:0] RST_TONE   = 8'h00;
   // ==========================================================
   // Field positions
   localparam int POW_EAR1_BIT  = 1;
   localparam int POW_EMUTE_BIT = 3;
   localparam int POW_SMUTE_BIT = 7;
   localparam int MODE_COMP_BIT = 4;
   localparam int MODE_TONE_BIT = 6;
   localparam int MODE_BUZZ_BIT = 3;
   localparam int TX_CODE_LSB   = 3;
   localparam int ST_CODE_LSB   = 0;
   localparam int RX_CODE_LSB   = 4;
   localparam int VOL_CODE_LSB  = 0;
   // ==========================================================
   // Gain limits (codes) and values in half dB, rx and sidetone tops in dB
   localparam logic [3:0] TX_EXT_LAST  = 4'h5;
   localparam logic [3:0] TX_NORM_FRST = 4'h8;
   localparam logic [3:0] TX_NORM_LAST = 4'hd;
   localparam logic [3:0] RX_LAST      = 4'hc;
   localparam logic [2:0] ST_LAST      = 3'h6;
   localparam logic [3:0] VOL_LAST     = 4'h9;
   localparam int         MIC2_EXT_HDB = 24;
   localparam int         TX_BASE_HDB  = 47;
   localparam int         RX_TOP_DB    = 6;
   localparam int         ST_TOP_DB    = -12;
   localparam int         HI_TONE_BOOST_HDB = 4;
   // ==========================================================
   // PCM word lengths
   localparam int COMP_BITS = 8;
   localparam int LIN_BITS  = 15;
   localparam int SLOT_BITS = 16;
   // ==========================================================
   // Tone step in mHz
   localparam int TONE_STEP_MHZ = 7813;
endpackage : codec_ctl_pkg

// [hw/codec_ctl_if.sv]
`timescale 1ns/1ns
interface codec_ctl_if;
   import codec_ctl_pkg::*;
   logic       wr_en;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       pcm_sync;
   logic       pcm_bit;
   modport dev  (input wr_en, addr, wdata, pcm_sync, pcm_bit,
                 output rdata);
   modport host (output wr_en, addr, wdata, pcm_sync, pcm_bit,
                 input rdata);
endinterface : codec_ctl_if

// [hw/codec_ctl_dev.sv]
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
module codec_ctl_dev (
   input  wire logic              pclk,
   input  wire logic              presetn,
   codec_ctl_if.dev               bus,
   output logic signed [7:0]      tx_gain_hdb,
   output logic                   mic2_boost,
   output logic signed [7:0]      rx_gain_db,
   output logic signed [7:0]      sidetone_db,
   output logic                   sidetone_mute,
   output logic signed [7:0]      volume_db,
   output logic                   earpiece_diff_en,
   output logic                   earpiece_single_en,
   output logic                   earphone_mute,
   output logic [7:0]             hi_tone_value,
   output logic [7:0]             lo_tone_value,
   output logic                   tone_active,
   output logic                   buzzer_pdm_out,
   output logic [14:0]            rx_word,
   output logic                   rx_word_valid
);
   import codec_ctl_pkg::*;

   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] regs;
      logic [3:0]               slot;
      logic [14:0]              shreg;
      logic                     sync_d;
      logic [14:0]              word;
      logic                     wvalid;
      logic [8:0]               acc;
      logic                     pdm;
   } state_s;
   state_s st_q, st_d;

   logic [3:0] txc;
   logic [3:0] rxc;
   logic [3:0] vc;
   logic [2:0] sc;
   logic       comp;
   logic [3:0] last_slot;
   assign txc  = st_q.regs[ADDR_TXPGA][TX_CODE_LSB+:4];
   assign sc   = st_q.regs[ADDR_TXPGA][ST_CODE_LSB+:3];
   assign rxc  = st_q.regs[ADDR_RXPGA][RX_CODE_LSB+:4];
   assign vc   = st_q.regs[ADDR_RXPGA][VOL_CODE_LSB+:4];
   assign comp = st_q.regs[ADDR_MODE][MODE_COMP_BIT];
   assign last_slot = comp ? 4'(COMP_BITS) : 4'(LIN_BITS);

   always_comb begin
      st_d = st_q;
      st_d.wvalid = 1'b0;
      if (bus.wr_en && (int'(bus.addr) < NUM_REGS)) begin
         st_d.regs[bus.addr] = bus.wdata;
      end
      // MSB first shift, word taken at last slot
      st_d.sync_d = bus.pcm_sync;
      if (bus.pcm_sync && !st_q.sync_d) begin
         st_d.slot  = 4'h1;
         st_d.shreg = {14'h0, bus.pcm_bit};
         if (last_slot == 4'h1) st_d.wvalid = 1'b1;
      end else if (st_q.slot != 4'h0) begin
         if (st_q.slot < last_slot) begin
            st_d.shreg = {st_q.shreg[13:0], bus.pcm_bit};
            st_d.slot  = st_q.slot + 4'h1;
            if (st_q.slot + 4'h1 == last_slot) begin
               st_d.word   = {st_q.shreg[13:0], bus.pcm_bit};
               st_d.wvalid = 1'b1;
            end
         end else begin
            st_d.slot = 4'h0;
         end
      end
      // first-order PDM from summed tone codes
      st_d.acc = {1'b0, st_q.acc[7:0]}
               + {1'b0, 8'(({1'b0, st_q.regs[ADDR_HITONE]}
                  + {1'b0, st_q.regs[ADDR_LOTONE]}) >> 1)};
      st_d.pdm = st_q.acc[8];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q.regs[ADDR_POWER]  <= RST_POWER;
         st_q.regs[ADDR_MODE]   <= RST_MODE;
         st_q.regs[ADDR_TXPGA]  <= RST_TXPGA;
         st_q.regs[ADDR_RXPGA]  <= RST_RXPGA;
         st_q.regs[ADDR_HITONE] <= RST_TONE;
         st_q.regs[ADDR_LOTONE] <= RST_TONE;
         st_q.slot   <= 4'h0;
         st_q.shreg  <= 15'h0;
         st_q.sync_d <= 1'b0;
         st_q.word   <= 15'h0;
         st_q.wvalid <= 1'b0;
         st_q.acc    <= 9'h0;
         st_q.pdm    <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // Output decode registered so every port is a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_gain_hdb        <= 8'sh0;
         mic2_boost         <= 1'b0;
         rx_gain_db         <= 8'sh0;
         sidetone_db        <= 8'sh0;
         sidetone_mute      <= 1'b0;
         volume_db          <= 8'sh0;
         earpiece_diff_en   <= 1'b0;
         earpiece_single_en <= 1'b0;
         earphone_mute      <= 1'b0;
         hi_tone_value      <= 8'h0;
         lo_tone_value      <= 8'h0;
         tone_active        <= 1'b0;
         buzzer_pdm_out     <= 1'b0;
         rx_word            <= 15'h0;
         rx_word_valid      <= 1'b0;
         bus.rdata          <= 8'h0;
      end else begin
         // tx decode, reserved codes take lowest gain
         if (txc <= TX_EXT_LAST) begin
            mic2_boost  <= 1'b1;
            tx_gain_hdb <= 8'(TX_BASE_HDB + MIC2_EXT_HDB
                              - 4 * int'(txc));
         end else if (txc >= TX_NORM_FRST && txc <= TX_NORM_LAST) begin
            mic2_boost  <= 1'b0;
            tx_gain_hdb <= 8'(TX_BASE_HDB - 4 * int'(txc - TX_NORM_FRST));
         end else begin
            mic2_boost  <= 1'b0;
            tx_gain_hdb <= 8'(TX_BASE_HDB - 4 * int'(TX_NORM_LAST
                                                      - TX_NORM_FRST));
         end
         rx_gain_db <= 8'(RX_TOP_DB - int'((rxc > RX_LAST) ? RX_LAST : rxc));
         sidetone_db <= 8'(ST_TOP_DB
                           - 2 * int'((sc > ST_LAST) ? ST_LAST : sc));
         sidetone_mute <= st_q.regs[ADDR_POWER][POW_SMUTE_BIT];
         volume_db <= 8'(-2 * int'((vc > VOL_LAST) ? VOL_LAST : vc));
         earpiece_diff_en   <= st_q.regs[ADDR_POWER][POW_EAR1_BIT];
         earpiece_single_en <= !st_q.regs[ADDR_POWER][POW_EAR1_BIT];
         earphone_mute <= st_q.regs[ADDR_POWER][POW_EMUTE_BIT];
         // tone values, high path gets boost downstream
         hi_tone_value <= st_q.regs[ADDR_HITONE];
         lo_tone_value <= st_q.regs[ADDR_LOTONE];
         tone_active   <= st_q.regs[ADDR_MODE][MODE_TONE_BIT];
         buzzer_pdm_out <= st_q.pdm && st_q.regs[ADDR_MODE][MODE_BUZZ_BIT];
         rx_word       <= comp ? {7'h0, st_q.word[7:0]} : st_q.word;
         rx_word_valid <= st_q.wvalid;
         bus.rdata <= (int'(bus.addr) < NUM_REGS) ? st_q.regs[bus.addr]
                                                  : 8'h0;
      end
   end
endmodule : codec_ctl_dev

// [hw/codec_ctl_host.sv]
`timescale 1ns/1ns
module codec_ctl_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   codec_ctl_if.host        bus,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   import codec_ctl_pkg::*;
   // Own map: 0x00-0x14 device regs, 0x20 PCM word to send
   localparam logic [11:0] PCM_TX_ADDR = 12'h020;

   typedef enum logic [1:0] {IDLE, WAITRD, SHIFT} host_e;
   typedef struct packed {
      host_e       fsm;
      logic [15:0] sreg;
      logic [4:0]  cnt;
      logic        wr;
      logic [2:0]  addr;
      logic [7:0]  wdata;
      logic        sync;
      logic        bit_o;
      logic        rdy;
      logic [31:0] rdat;
      logic        err;
   } hstate_s;
   hstate_s s_q, s_d;

   logic acc;
   assign acc = psel && penable && !s_q.rdy;

   always_comb begin
      s_d = s_q;
      s_d.wr   = 1'b0;
      s_d.rdy  = 1'b0;
      s_d.sync = 1'b0;
      case (s_q.fsm)
         IDLE: begin
            if (acc) begin
               s_d.err = 1'b0;
               if (paddr == PCM_TX_ADDR && pwrite) begin
                  s_d.sreg = pwdata[15:0];
                  s_d.cnt  = 5'(SLOT_BITS);
                  s_d.fsm  = SHIFT;
               end else if (paddr[11:5] == 7'h0 && paddr[1:0] == 2'b00
                            && int'(paddr[4:2]) < NUM_REGS) begin
                  s_d.addr = paddr[4:2];
                  if (pwrite) begin
                     s_d.wr    = 1'b1;
                     s_d.wdata = pwdata[7:0];
                     s_d.rdy   = 1'b1;
                  end else begin
                     s_d.fsm = WAITRD;
                     s_d.cnt = 5'h2;
                  end
               end else begin
                  s_d.err = 1'b1;
                  s_d.rdat = 32'h0;
                  s_d.rdy = 1'b1;
               end
            end
         end
         WAITRD: begin
            s_d.cnt = s_q.cnt - 5'h1;
            if (s_q.cnt == 5'h1) begin
               s_d.rdat = {24'h0, bus.rdata};
               s_d.rdy  = 1'b1;
               s_d.fsm  = IDLE;
            end
         end
         SHIFT: begin
            s_d.sync  = (s_q.cnt == 5'(SLOT_BITS));
            s_d.bit_o = s_q.sreg[15];
            s_d.sreg  = {s_q.sreg[14:0], 1'b0};
            s_d.cnt   = s_q.cnt - 5'h1;
            if (s_q.cnt == 5'h1) begin
               s_d.rdy = 1'b1;
               s_d.fsm = IDLE;
            end
         end
         default: s_d.fsm = IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.fsm <= IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.wr_en    = s_q.wr;
   assign bus.addr     = s_q.addr;
   assign bus.wdata    = s_q.wdata;
   assign bus.pcm_sync = s_q.sync;
   assign bus.pcm_bit  = s_q.bit_o;
   assign prdata  = s_q.rdat;
   assign pready  = s_q.rdy;
   assign pslverr = s_q.err;
endmodule : codec_ctl_host

// [tb/codec_ctl_assertions.sv]
`timescale 1ns/1ns
module codec_ctl_assertions
   import codec_ctl_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              wr_en,
   input wire logic [2:0]        addr,
   input wire logic [7:0]        wdata,
   input wire logic              pcm_sync,
   input wire logic signed [7:0] tx_gain_hdb,
   input wire logic              mic2_boost,
   input wire logic signed [7:0] rx_gain_db,
   input wire logic signed [7:0] sidetone_db,
   input wire logic              sidetone_mute,
   input wire logic signed [7:0] volume_db,
   input wire logic              earpiece_diff_en,
   input wire logic              earpiece_single_en,
   input wire logic              earphone_mute,
   input wire logic [7:0]        hi_tone_value,
   input wire logic [7:0]        lo_tone_value,
   input wire logic              tone_active,
   input wire logic              buzzer_pdm_out,
   input wire logic [14:0]       rx_word,
   input wire logic              rx_word_valid
);
   // ========
   // Register shadow fed by link writes
   logic [7:0] reg_q [8];
   logic [2:0] age_q;
   int         tc, rc, sc, vc, tx_e;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_q <= '{RST_POWER, RST_MODE, RST_TXPGA, RST_RXPGA, RST_TONE,
                    RST_TONE, 8'h00, 8'h00};
         age_q <= 3'h0;
      end else if (wr_en) begin
         reg_q[addr] <= wdata;
         age_q       <= 3'h0;
      end else if (age_q != 3'h7) begin
         age_q <= age_q + 3'h1;
      end
   end
   // Outputs may lag a write; judge them once settled
   wire calm = age_q > 3'h2;
   assign tc = int'(reg_q[2][6:3]);
   assign rc = int'(reg_q[3][7:4]);
   assign sc = int'(reg_q[2][2:0]);
   assign vc = int'(reg_q[3][3:0]);
   assign tx_e = tc < 6 ? 71 - 4 * tc :
                 (tc > 7 && tc < 14) ? 79 - 4 * tc : 27;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ========
   // Properties
   a_tx_gain: assert property (calm |-> tx_gain_hdb == 8'(tx_e))
      else $error("tx gain wrong");
   a_mic_boost: assert property (calm |-> mic2_boost == (tc < 6))
      else $error("mic boost wrong");
   a_rx_gain: assert property (calm |->
      rx_gain_db == 8'(rc < 13 ? 6 - rc : -6)) else $error("rx gain wrong");
   a_side_gain: assert property (calm |->
      sidetone_db == 8'(sc < 7 ? -12 - 2 * sc : -24))
      else $error("sidetone gain wrong");
   a_vol_gain: assert property (calm |->
      volume_db == 8'(vc < 10 ? -2 * vc : -18)) else $error("volume wrong");
   a_side_mute: assert property (calm |-> sidetone_mute == reg_q[0][7])
      else $error("sidetone mute wrong");
   a_ear_mute: assert property (calm |-> earphone_mute == reg_q[0][3])
      else $error("earphone mute wrong");
   a_one_ear: assert property (calm |-> earpiece_diff_en == reg_q[0][1]
      && earpiece_single_en == !reg_q[0][1]) else $error("earpiece wrong");
   a_tone_regs: assert property (calm |-> hi_tone_value == reg_q[4]
      && lo_tone_value == reg_q[5]) else $error("tone value wrong");
   a_tone_mode: assert property (calm |->
      tone_active == reg_q[1][MODE_TONE_BIT]) else $error("tone mode wrong");
   a_buzz_gate: assert property (calm && !reg_q[1][3] |->
      !buzzer_pdm_out) else $error("buzzer not gated");
   a_comp_word: assert property (rx_word_valid && reg_q[1][4] |->
      rx_word[14:8] == 7'h00) else $error("companded word too wide");
   a_sync_once: assert property (pcm_sync |=> !pcm_sync [*8])
      else $error("sync repeated in word");
endmodule : codec_ctl_assertions

// [tb/voice_codec_gain_tone_control_test.sv]
`timescale 1ns/1ns
module voice_codec_gain_tone_control_test;
   import codec_ctl_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata;
   logic signed [7:0] tx_gain_hdb, rx_gain_db, sidetone_db, volume_db;
   logic              mic2_boost, sidetone_mute, earphone_mute, rx_word_valid;
   logic              earpiece_diff_en, earpiece_single_en, buzzer_pdm_out;
   logic [7:0]        hi_tone_value, lo_tone_value, v;
   logic [14:0]       rx_word;
   logic              tone_active;
   logic [15:0]       d;
   logic [33:0]       e;
   logic [33:0]       eq[$];
   logic [14:0]       wq[$];
   int                errors, comparisons, seed, i, j, n;
   logic [7:0]        dflt [6] = '{RST_POWER, RST_MODE, RST_TXPGA,
                                   RST_RXPGA, RST_TONE, RST_TONE};
   codec_ctl_if cif ();
   codec_ctl_dev u_codec_ctl_dev (
      .pclk, .presetn, .bus(cif), .tx_gain_hdb, .mic2_boost, .rx_gain_db,
      .sidetone_db, .sidetone_mute, .volume_db, .earpiece_diff_en,
      .earpiece_single_en, .earphone_mute, .hi_tone_value, .lo_tone_value,
      .tone_active, .buzzer_pdm_out, .rx_word, .rx_word_valid);
   codec_ctl_host u_codec_ctl_host (
      .pclk, .presetn, .bus(cif), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);
   codec_ctl_assertions u_codec_ctl_assertions (
      .pclk, .presetn, .wr_en(cif.wr_en), .addr(cif.addr),
      .wdata(cif.wdata), .pcm_sync(cif.pcm_sync), .tx_gain_hdb,
      .mic2_boost, .rx_gain_db, .sidetone_db, .sidetone_mute, .volume_db,
      .earpiece_diff_en, .earpiece_single_en, .earphone_mute,
      .hi_tone_value, .lo_tone_value, .tone_active, .buzzer_pdm_out,
      .rx_word, .rx_word_valid);
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // ========
   // Checking
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         errors++;
         $display("Error at %0t: saw %h want %h", $time, s, x);
      end
   endtask : chk
   task print_verdict;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         e = eq.pop_front();
         chk({31'h0, pslverr}, {31'h0, e[32]});
         if (e[33]) chk(prdata, e[31:0]);
      end
      if (rx_word_valid === 1'b1) begin
         chk({17'h0, rx_word}, {17'h0, wq.pop_front()});
      end
   end
   // ========
   // Bus master
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] x, input logic [33:0] ex);
      int k;
      @(posedge pclk);
      eq.push_back(ex);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= x;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 64);
      if (k == 64) begin
         errors++;
         print_verdict;
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [7:0] x);
      apb(1'b1, a, {24'h0, x}, 34'h0);
   endtask : wr
   task rd(input logic [11:0] a, input logic [7:0] x);
      apb(1'b0, a, 32'h0, {2'b10, 24'h0, x});
   endtask : rd
   task rst;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
   endtask : rst
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      seed = 10050;
      rst;
      for (i = 0; i < 6; i++) rd(12'(4 * i), dflt[i]);
      $display("test reset done");
      for (i = 0; i < 16; i++) begin
         for (j = 0; j < 6; j++) begin
            v = 8'($random(seed));
            if (j == 2) v[6:3] = 4'(i);
            if (j == 3) v = {4'(i), 4'(15 - i)};
            wr(12'(4 * j), v);
            rd(12'(4 * j), v);
         end
      end
      $display("test codes done");
      apb(1'b1, 12'h015, 32'hff, {2'b11, 32'h0});
      apb(1'b0, 12'h018, 32'h0, {2'b11, 32'h0});
      apb(1'b1, 12'h100, 32'h0, {2'b11, 32'h0});
      rd(12'h014, v);
      $display("test refuse done");
      for (i = 0; i < 8; i++) begin
         if (i % 4 == 0) wr(12'h004, i < 4 ? 8'h10 : 8'h00);
         d = 16'($random(seed));
         wq.push_back(i < 4 ? {7'h00, d[15:8]} : d[15:1]);
         apb(1'b1, 12'h020, {16'h0, d}, 34'h0);
      end
      n = 0;
      while (wq.size() != 0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      if (n == 100) errors++;
      $display("test pcm done");
      wr(12'h010, 8'h9b);
      rst;
      rd(12'h010, RST_TONE);
      $display("test rerun done");
      print_verdict;
   end
endmodule : voice_codec_gain_tone_control_test
